// >>> hdl/unbalance_pkg.sv
// What this block does
// - Mode setting picks per-unit or ratio supervision.
// - Take sequence and phase values every 5 ms.
// - Ratio mode checks minimum phase loading first.
// - Pick up above level, drop below 97 %.
// - Per-unit level in 0.01 steps, default 0.2.
// - Ratio level in 0.01 % steps, default 20 %.
// - Blocking input sampled each program cycle.
// - Unblocked pick-up gives start and timing.
// - Blocked pick-up gives blocked, nothing else.
// - Late blocking drops start, runs release handling.
// - Blocking issues event with currents, fault type.
// - Force status other than normal overrides outputs when forcing enabled.
// - Readable condition: normal, start, trip, blocked.
// - Instant mode: start and trip together.
// - On and off events, 1 ms timestamps.
// - Start, trip, blocked counters, clearable.
// - Definite delay fixed; inverse from measured I2 and per-unit level.
// - Curve time is k over squared difference.
// - Release 60 ms default, operate time held.
// - Keep-count release option; trip needs re-pick-up.
// - Eight setting groups, switchable while running.
package unbalance_pkg;

    // Clock and time base.
    localparam int CLK_PERIOD_NS = 40;
    localparam int MS_NS         = 1000000;
    localparam int CYC_PER_MS    = MS_NS / CLK_PERIOD_NS;
    localparam int TICK_MS       = 5;

    // Comparator scaling: ratios in 0.01 %, so 100 % is 10000.
    localparam int RATIO_FULL      = 10000;
    localparam int RESET_RATIO_PCT = 97;
    localparam int PCT_FULL        = 100;

    // Measured magnitude selector values.
    localparam logic [1:0] MODE_PU    = 2'h1;
    localparam logic [1:0] MODE_RATIO = 2'h2;

    // Delay mode selector values.
    localparam logic [1:0] DLY_INSTANT  = 2'h0;
    localparam logic [1:0] DLY_DEFINITE = 2'h1;
    localparam logic [1:0] DLY_INVERSE  = 2'h2;

    // Condition and force codes.
    localparam logic [1:0] COND_NORMAL  = 2'h0;
    localparam logic [1:0] COND_START   = 2'h1;
    localparam logic [1:0] COND_TRIP    = 2'h2;
    localparam logic [1:0] COND_BLOCKED = 2'h3;

    // Register byte addresses.
    localparam logic [8:0] ADDR_CTRL      = 9'h000;
    localparam logic [8:0] ADDR_STATUS    = 9'h004;
    localparam logic [8:0] ADDR_CNT_START = 9'h008;
    localparam logic [8:0] ADDR_CNT_TRIP  = 9'h00C;
    localparam logic [8:0] ADDR_CNT_BLOCK = 9'h010;
    localparam logic [8:0] ADDR_CNT_CLEAR = 9'h014;
    localparam logic [8:0] ADDR_TIME_MS   = 9'h018;
    localparam logic [8:0] ADDR_SET_BASE  = 9'h040;
    localparam logic [8:0] ADDR_SET_LAST  = 9'h13C;

    // Control register fields.
    localparam int CTRL_MODE_LSB  = 0;
    localparam int CTRL_DLY_LSB   = 2;
    localparam int CTRL_KEEP_BIT  = 4;
    localparam int CTRL_FEN_BIT   = 5;
    localparam int CTRL_FST_LSB   = 6;
    localparam int CTRL_GRP_LSB   = 8;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0001;

    // Setting fields inside one group of eight words.
    localparam logic [2:0] F_PU_LEVEL  = 3'h0;
    localparam logic [2:0] F_RATIO_LVL = 3'h1;
    localparam logic [2:0] F_MIN_LOAD  = 3'h2;
    localparam logic [2:0] F_DELAY_MS  = 3'h3;
    localparam logic [2:0] F_CURVE_K   = 3'h4;
    localparam logic [2:0] F_RELEASE   = 3'h5;

    // Setting defaults (levels in 0.01 x In, ratio in 0.01 %).
    localparam logic [31:0] DEF_PU_LEVEL  = 32'h0000_0014;
    localparam logic [31:0] DEF_RATIO_LVL = 32'h0000_07D0;
    localparam logic [31:0] DEF_MIN_LOAD  = 32'h0000_000A;
    localparam logic [31:0] DEF_DELAY_MS  = 32'h0000_0064;
    localparam logic [31:0] DEF_CURVE_K   = 32'h0001_86A0;
    localparam logic [31:0] DEF_RELEASE   = 32'h0000_003C;

    // Reset value of one setting word by field.
    function automatic logic [31:0] set_default(input logic [2:0] f);
        unique case (f)
            F_PU_LEVEL:  return DEF_PU_LEVEL;
            F_RATIO_LVL: return DEF_RATIO_LVL;
            F_MIN_LOAD:  return DEF_MIN_LOAD;
            F_DELAY_MS:  return DEF_DELAY_MS;
            F_CURVE_K:   return DEF_CURVE_K;
            F_RELEASE:   return DEF_RELEASE;
            default:     return 32'h0000_0000;
        endcase
    endfunction

    // One 5 ms measurement frame from the preprocessor.
    typedef struct packed {
        logic [15:0] pos_seq_magnitude;
        logic [15:0] neg_seq_magnitude;
        logic [15:0] zero_seq_magnitude;
        logic [15:0] pos_seq_angle;
        logic [15:0] neg_seq_angle;
        logic [15:0] zero_seq_angle;
        logic [15:0] phase_a_rms;
        logic [15:0] phase_b_rms;
        logic [15:0] phase_c_rms;
    } meas_t;

    // Stage outputs as a group.
    typedef struct packed {
        logic start;
        logic trip;
        logic blocked;
    } outs_t;

    // One event record: changed outputs, new levels, time, data.
    typedef struct packed {
        logic        valid;
        outs_t       changed;
        outs_t       level;
        logic [31:0] time_ms;
        logic [1:0]  fault_type;
        meas_t       data;
    } event_t;

endpackage

// >>> hdl/unbalance_stage.sv
// Design decisions made here: the register offsets and the strobed register port.
`timescale 1ns/1ns
module unbalance_stage #(
    parameter int CYC_PER_MS = unbalance_pkg::CYC_PER_MS
) (
    // Clock and reset.
    input  wire logic                  clk_i,
    input  wire logic                  reset_i,
    // Register port.
    input  wire logic [8:0]            addr_i,
    input  wire logic [31:0]           wdata_i,
    input  wire logic                  wr_i,
    input  wire logic                  rd_i,
    output logic [31:0]                rdata_o,
    // Measurements and blocking.
    input  wire unbalance_pkg::meas_t  meas_i,
    input  wire logic                  meas_valid_i,
    input  wire logic                  block_i,
    // Stage outputs.
    output logic                       start_o,
    output logic                       trip_o,
    output logic                       blocked_o,
    output logic [1:0]                 condition_o,
    output unbalance_pkg::event_t      event_o
);

    // Stage states.
    typedef enum logic [2:0] {
        ST_IDLE, ST_START, ST_RELEASE, ST_TRIP, ST_BLOCKED
    } state_t;

    logic [31:0]          ctrl_r;              // Control word.
    logic [31:0]          settings_r [0:63];   // Eight groups of eight.
    logic [31:0]          rdata_r;             // Read data register.
    unbalance_pkg::meas_t meas_r;              // Latched frame.
    logic                 eval_r;              // Evaluate this cycle.
    logic                 blk_meta_r;          // Sync stage one.
    logic                 blk_sync_r;          // Sync stage two.
    logic                 pickup_r;            // Comparator state.
    state_t               state_r;             // Stage state.
    state_t               state_nxt;
    logic [47:0]          acc_r;               // Operate accumulator.
    logic [47:0]          acc_nxt;
    logic [31:0]          rel_r;               // Release time, ms.
    logic [31:0]          rel_nxt;
    unbalance_pkg::outs_t out_r;               // Registered outputs.
    unbalance_pkg::outs_t out_nxt;
    unbalance_pkg::event_t event_r;            // Event record.
    logic [31:0]          cnt_start_r;         // Start count.
    logic [31:0]          cnt_trip_r;          // Trip count.
    logic [31:0]          cnt_block_r;         // Blocked count.
    logic [31:0]          ms_div_r;            // Cycles within 1 ms.
    logic [31:0]          time_ms_r;           // Millisecond clock.

    // Two flops for the blocking input, which comes from outside.
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            blk_meta_r <= 1'b0;
            blk_sync_r <= 1'b0;
        end else begin
            blk_meta_r <= block_i;
            blk_sync_r <= blk_meta_r;
        end
    end

    // Control fields.
    wire [1:0] mode     = ctrl_r[unbalance_pkg::CTRL_MODE_LSB +: 2];
    wire [1:0] dly_mode = ctrl_r[unbalance_pkg::CTRL_DLY_LSB +: 2];
    wire       keep_cnt = ctrl_r[unbalance_pkg::CTRL_KEEP_BIT];
    wire       force_en = ctrl_r[unbalance_pkg::CTRL_FEN_BIT];
    wire [1:0] force_st = ctrl_r[unbalance_pkg::CTRL_FST_LSB +: 2];
    wire [2:0] grp      = ctrl_r[unbalance_pkg::CTRL_GRP_LSB +: 3];
    wire       is_ratio = (mode == unbalance_pkg::MODE_RATIO);

    // Active group settings; a group change applies at once.
    wire [5:0]  gbase    = {grp, 3'h0};
    wire [15:0] pu_set   = settings_r[gbase | 6'(unbalance_pkg::F_PU_LEVEL)][15:0];
    wire [15:0] rat_set  = settings_r[gbase | 6'(unbalance_pkg::F_RATIO_LVL)][15:0];
    wire [15:0] min_load = settings_r[gbase | 6'(unbalance_pkg::F_MIN_LOAD)][15:0];
    wire [31:0] delay_ms = settings_r[gbase | 6'(unbalance_pkg::F_DELAY_MS)];
    wire [31:0] curve_k  = settings_r[gbase | 6'(unbalance_pkg::F_CURVE_K)];
    wire [31:0] rel_ms   = settings_r[gbase | 6'(unbalance_pkg::F_RELEASE)];

    // Supervised quantity against level, cross-multiplied so that
    // the ratio mode needs no divider.
    wire [47:0] i2_w   = 48'(meas_r.neg_seq_magnitude);
    wire [47:0] num    = is_ratio ? i2_w * 48'(unbalance_pkg::RATIO_FULL)
                                  : i2_w;
    wire [47:0] den    = is_ratio ? 48'(rat_set) *
                                    48'(meas_r.pos_seq_magnitude)
                                  : 48'(pu_set);
    wire        pick_on  = num > den;
    wire        pick_off = num * 48'(unbalance_pkg::PCT_FULL) <
                           den * 48'(unbalance_pkg::RESET_RATIO_PCT);
    wire        load_ok  = !is_ratio ||
                           ((meas_r.phase_a_rms >= min_load) &&
                            (meas_r.phase_b_rms >= min_load) &&
                            (meas_r.phase_c_rms >= min_load));
    wire        pick_nxt = load_ok &&
                           (pickup_r ? !pick_off : pick_on);

    // Squared-difference curve: trip once the sum of
    // (I2^2 - Iset^2) * dt reaches k, the integral form of k / diff.
    wire [47:0] i2_sq  = i2_w * i2_w;
    wire [47:0] set_sq = 48'(pu_set) * 48'(pu_set);
    wire [47:0] inc    = (dly_mode == unbalance_pkg::DLY_DEFINITE) ?
                         48'(unbalance_pkg::TICK_MS) :
                         (i2_sq > set_sq) ?
                         (i2_sq - set_sq) * 48'(unbalance_pkg::TICK_MS) :
                         48'h0;
    wire [47:0] limit  = (dly_mode == unbalance_pkg::DLY_DEFINITE) ?
                         48'(delay_ms) : 48'(curve_k);
    wire [47:0] acc_up = acc_r + inc;
    wire [31:0] rel_up = rel_r + 32'(unbalance_pkg::TICK_MS);
    wire        blk    = blk_sync_r;

    // Stage sequencing, stepped only on evaluation cycles.
    always_comb begin
        state_nxt = state_r;
        acc_nxt   = acc_r;
        rel_nxt   = rel_r;
        if (eval_r) begin
            unique case (state_r)
                ST_IDLE: begin
                    if (pick_nxt && blk) begin
                        state_nxt = ST_BLOCKED;
                    end else if (pick_nxt) begin
                        acc_nxt   = 48'h0;
                        state_nxt = (dly_mode == unbalance_pkg::DLY_INSTANT)
                                    ? ST_TRIP : ST_START;
                    end
                end
                ST_START: begin
                    if (!pick_nxt || blk) begin
                        rel_nxt   = 32'h0;
                        state_nxt = ST_RELEASE;
                    end else begin
                        acc_nxt = acc_up;
                        if (acc_up >= limit) begin
                            state_nxt = ST_TRIP;
                        end
                    end
                end
                ST_RELEASE: begin
                    // Held time by default; keep-count keeps adding.
                    if (keep_cnt) begin
                        acc_nxt = acc_up;
                    end
                    if (pick_nxt && !blk) begin
                        state_nxt = ST_START;
                    end else if (rel_up >= rel_ms) begin
                        acc_nxt   = 48'h0;
                        state_nxt = ST_IDLE;
                    end else begin
                        rel_nxt = rel_up;
                    end
                end
                ST_TRIP: begin
                    if (!pick_nxt) begin
                        acc_nxt   = 48'h0;
                        state_nxt = ST_IDLE;
                    end else if (blk) begin
                        state_nxt = ST_BLOCKED;
                    end
                end
                ST_BLOCKED: begin
                    if (!pick_nxt) begin
                        acc_nxt   = 48'h0;
                        state_nxt = ST_IDLE;
                    end
                end
            endcase
        end
    end

    // Raw outputs from the state, then the commissioning override.
    wire raw_start = (state_nxt == ST_START) || (state_nxt == ST_TRIP);
    wire raw_trip  = (state_nxt == ST_TRIP);
    wire raw_blk   = (state_nxt == ST_BLOCKED);
    wire forced    = force_en && (force_st != unbalance_pkg::COND_NORMAL);
    always_comb begin
        if (forced) begin
            out_nxt.start   = (force_st == unbalance_pkg::COND_START) ||
                              (force_st == unbalance_pkg::COND_TRIP);
            out_nxt.trip    = (force_st == unbalance_pkg::COND_TRIP);
            out_nxt.blocked = (force_st == unbalance_pkg::COND_BLOCKED);
        end else begin
            out_nxt.start   = raw_start;
            out_nxt.trip    = raw_trip;
            out_nxt.blocked = raw_blk;
        end
    end
    wire [2:0] out_rise = out_nxt & ~out_r;
    wire [2:0] out_chg  = out_nxt ^ out_r;

    // Frame latch, evaluation strobe and stage state.
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            meas_r   <= '0;
            eval_r   <= 1'b0;
            pickup_r <= 1'b0;
            state_r  <= ST_IDLE;
            acc_r    <= 48'h0;
            rel_r    <= 32'h0;
            out_r    <= '0;
        end else begin
            if (meas_valid_i) begin
                meas_r <= meas_i;
            end
            eval_r  <= meas_valid_i;
            if (eval_r) begin
                pickup_r <= pick_nxt;
            end
            state_r <= state_nxt;
            acc_r   <= acc_nxt;
            rel_r   <= rel_nxt;
            out_r   <= out_nxt;
        end
    end

    // Millisecond time base for event stamps.
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            ms_div_r  <= 32'h0;
            time_ms_r <= 32'h0;
        end else if (ms_div_r == 32'(CYC_PER_MS - 1)) begin
            ms_div_r  <= 32'h0;
            time_ms_r <= time_ms_r + 32'h1;
        end else begin
            ms_div_r <= ms_div_r + 32'h1;
        end
    end

    // One event per output change; simultaneous changes share a
    // record and therefore one stamp.
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            event_r <= '0;
        end else begin
            event_r.valid      <= |out_chg;
            event_r.changed    <= out_chg;
            event_r.level      <= out_nxt;
            event_r.time_ms    <= time_ms_r;
            event_r.fault_type <= mode;
            event_r.data       <= meas_r;
        end
    end

    // Register port decode.
    wire in_set   = (addr_i >= unbalance_pkg::ADDR_SET_BASE) &&
                    (addr_i <= unbalance_pkg::ADDR_SET_LAST);
    wire [8:0] set_off = addr_i - unbalance_pkg::ADDR_SET_BASE;
    wire [5:0] set_idx = set_off[7:2];
    wire wr_ctrl  = wr_i && (addr_i == unbalance_pkg::ADDR_CTRL);
    wire wr_set   = wr_i && in_set;
    wire wr_clr   = wr_i && (addr_i == unbalance_pkg::ADDR_CNT_CLEAR);
    wire [2:0] clr = wr_clr ? wdata_i[2:0] : 3'h0;
    wire [31:0] status_w = {26'h0, pickup_r, out_r.blocked, out_r.trip,
                            out_r.start, condition_o};
    wire [31:0] rd_val =
        (addr_i == unbalance_pkg::ADDR_CTRL)      ? ctrl_r      :
        (addr_i == unbalance_pkg::ADDR_STATUS)    ? status_w    :
        (addr_i == unbalance_pkg::ADDR_CNT_START) ? cnt_start_r :
        (addr_i == unbalance_pkg::ADDR_CNT_TRIP)  ? cnt_trip_r  :
        (addr_i == unbalance_pkg::ADDR_CNT_BLOCK) ? cnt_block_r :
        (addr_i == unbalance_pkg::ADDR_TIME_MS)   ? time_ms_r   :
        in_set                                    ? settings_r[set_idx] :
                                                    32'h0;

    // Control, settings and read data; groups reset to defaults.
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            ctrl_r  <= unbalance_pkg::CTRL_RESET;
            rdata_r <= 32'h0;
            for (int i = 0; i < 64; i++) begin
                settings_r[i] <= unbalance_pkg::set_default(3'(i));
            end
        end else begin
            if (wr_ctrl) begin
                ctrl_r <= wdata_i;
            end
            if (wr_set) begin
                settings_r[set_idx] <= wdata_i;
            end
            rdata_r <= rd_i ? rd_val : 32'h0;
        end
    end

    // Counters: a count in the clearing cycle wins and leaves 1.
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            cnt_start_r <= 32'h0;
            cnt_trip_r  <= 32'h0;
            cnt_block_r <= 32'h0;
        end else begin
            cnt_start_r <= out_rise[2] ? (clr[0] ? 32'h1 : cnt_start_r + 1'b1)
                         : (clr[0] ? 32'h0 : cnt_start_r);
            cnt_trip_r  <= out_rise[1] ? (clr[1] ? 32'h1 : cnt_trip_r + 1'b1)
                         : (clr[1] ? 32'h0 : cnt_trip_r);
            cnt_block_r <= out_rise[0] ? (clr[2] ? 32'h1 : cnt_block_r + 1'b1)
                         : (clr[2] ? 32'h0 : cnt_block_r);
        end
    end

    // Output drive.
    assign rdata_o     = rdata_r;
    assign start_o     = out_r.start;
    assign trip_o      = out_r.trip;
    assign blocked_o   = out_r.blocked;
    assign condition_o = out_r.trip    ? unbalance_pkg::COND_TRIP    :
                         out_r.blocked ? unbalance_pkg::COND_BLOCKED :
                         out_r.start   ? unbalance_pkg::COND_START   :
                                         unbalance_pkg::COND_NORMAL;
    assign event_o     = event_r;

    // Checks.
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);

    sequence s_idle_pick;
        eval_r && state_r == ST_IDLE && pick_nxt;
    endsequence

    a_pick_level_up: assert property (
        $rose(pickup_r) |-> $past(eval_r && pick_on && load_ok))
        else $error("pick-up rose without level exceeded");
    a_pick_level_down: assert property (
        $fell(pickup_r) && $past(load_ok) |-> $past(pick_off))
        else $error("pick-up fell above reset level");
    a_trip_has_start: assert property (
        trip_o |-> start_o)
        else $error("trip without start");
    // The record with both rises stands only in the cycle after eval.
    a_instant_trip: assert property (
        s_idle_pick ##0 (!blk && dly_mode == unbalance_pkg::DLY_INSTANT
        && !forced) |=> (trip_o && start_o && event_o.changed == 3'h6))
        else $error("instant trip not with start");
    a_block_hold: assert property (
        s_idle_pick ##0 (blk && !forced) |=> ##1
        (blocked_o && !start_o && !trip_o))
        else $error("blocked pick-up did not block");
    a_block_drop: assert property (
        eval_r && state_r == ST_START && blk |=> state_r == ST_RELEASE)
        else $error("late blocking kept start");
    a_event_change: assert property (
        (out_r != $past(out_r)) |-> event_o.valid &&
        event_o.level == out_r)
        else $error("output change without event");
    a_count_start: assert property (
        $rose(start_o) && !$past(clr[0]) |->
        cnt_start_r == $past(cnt_start_r) + 32'h1)
        else $error("start counter missed");
    a_release_hold: assert property (
        state_r == ST_RELEASE && state_nxt == ST_RELEASE && !keep_cnt
        |=> acc_r == $past(acc_r))
        else $error("accumulator moved while held");

    // Forcing replaces the outputs one cycle after the control word
    // asks for it, whatever the stage state is.
    a_force_blocked: assert property (
        forced && force_st == unbalance_pkg::COND_BLOCKED |=>
        blocked_o && !start_o && !trip_o)
        else $error("forced blocked not shown");
    // Start alone must read back as the start code.
    a_cond_start: assert property (
        start_o && !trip_o && !blocked_o |->
        condition_o == unbalance_pkg::COND_START)
        else $error("condition does not show start");
    // A definite-time trip needs the full delay already counted.
    a_definite_wait: assert property (
        $rose(trip_o) && $past(state_r == ST_START && !forced &&
        dly_mode == unbalance_pkg::DLY_DEFINITE) |->
        $past(acc_r) + 48'(unbalance_pkg::TICK_MS) >= 48'(delay_ms))
        else $error("definite trip before its delay");

endmodule // unbalance_stage

// >>> verif/meas_source.sv
`timescale 1ns/1ns
// Stand-in for the preprocessor and blocking matrix: one frame every
// 5 ms. Requests are taken right after a frame, shown in the next one.
module meas_source #(
    parameter int FRAME = 50
) (
    // Clock and reset.
    input  wire logic            clk_i,
    input  wire logic            reset_i,
    // Requested values.
    input  wire logic [15:0]     neg_i,
    input  wire logic            block_req_i,
    // Frame and blocking.
    output unbalance_pkg::meas_t meas_o,
    output logic                 meas_valid_o,
    output logic                 block_o
);
    int cnt_r; // Cycle count inside one frame period.

    // Phases and positive sequence sit at nominal load.
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            cnt_r <= 0;
            meas_valid_o <= 1'b0;
            meas_o <= '0;
            block_o <= 1'b0;
        end else begin
            cnt_r <= (cnt_r == FRAME - 1) ? 0 : cnt_r + 1;
            meas_valid_o <= (cnt_r == FRAME - 1);
            // Both move together, so blocking has passed the stage's
            // synchroniser long before the frame that carries the step.
            if (cnt_r == 0) begin
                meas_o  <= {16'h0064, neg_i, 64'h0, {3{16'h0064}}};
                block_o <= block_req_i;
            end
        end
    end
endmodule // meas_source

// >>> verif/unbalance_stage_tb.sv
`timescale 1ns/1ns
module unbalance_stage_tb;
    logic                 clk_i = 1'b0;
    logic                 reset_i = 1'b1;
    logic [8:0]           addr_i = 9'h000;
    logic [31:0]          wdata_i = 32'h0000_0000;
    logic                 wr_i = 1'b0;
    logic                 rd_i = 1'b0;
    logic [15:0]          neg_r = 16'h0000; // Requested negative sequence.
    logic                 blk_r = 1'b0;     // Requested blocking level.
    logic [31:0]          rdata_o;
    unbalance_pkg::meas_t meas_i;
    unbalance_pkg::event_t event_o;
    logic                 meas_valid_i, block_i, start_o, trip_o, blocked_o;
    logic [1:0]           condition_o;
    int                   miscompares = 0;
    int                   num_checks = 0;
    unbalance_pkg::event_t ev_first;          // First event record.
    logic                 ev_seen = 1'b0;

    // Keep the first event record, which stands for one cycle only.
    always @(posedge clk_i) begin
        if (event_o.valid && !ev_seen) begin
            ev_first <= event_o;
            ev_seen  <= 1'b1;
        end
    end

    // Ten cycles per ms keeps a 5 ms frame at 50 cycles.
    unbalance_stage #(.CYC_PER_MS(10)) dut_u (.clk_i, .reset_i, .addr_i,
        .wdata_i, .wr_i, .rd_i, .rdata_o, .meas_i, .meas_valid_i,
        .block_i, .start_o, .trip_o, .blocked_o, .condition_o, .event_o);
    meas_source #(.FRAME(50)) src_u (.clk_i, .reset_i, .neg_i(neg_r),
        .block_req_i(blk_r), .meas_o(meas_i),
        .meas_valid_o(meas_valid_i), .block_o(block_i));

    always #20 clk_i = ~clk_i;

    task automatic check(input string nm, input logic [31:0] s, e);
        num_checks++;
        if (s !== e) begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic wr(input logic [8:0] a, input logic [31:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe.
    task automatic rc(input string nm, input logic [8:0] a, logic [31:0] e);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 check(nm, rdata_o, e);
    endtask
    // The stage evaluates once a frame, so waits count whole frames.
    task automatic frames(input int n);
        repeat (n * 50) @(posedge clk_i);
        #1;
    endtask
    task automatic complete_run();
        if (miscompares == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial begin
        repeat (4) @(posedge clk_i);
        reset_i <= 1'b0;
        rc("ctrl", unbalance_pkg::ADDR_CTRL, 32'h0000_0001);
        rc("pu_lvl", 9'h040, 32'h0000_0014);
        rc("ratio_lvl", 9'h044, 32'h0000_07D0);
        rc("release", 9'h054, 32'h0000_003C);
        neg_r <= 16'h001E;
        frames(2);
        check("start", start_o, 1'b1);
        check("trip", trip_o, 1'b1);
        check("cond", condition_o, unbalance_pkg::COND_TRIP);
        // The second frame carries the step, 10 ms after reset.
        check("ev_chg", ev_first.changed, 3'h6);
        check("ev_time", ev_first.time_ms, 32'h0000_000A);
        check("ev_data", ev_first.data.neg_seq_magnitude, 16'h001E);
        // Twenty still sits above the 97 % drop-out point.
        neg_r <= 16'h0014;
        frames(2);
        check("hold", start_o, 1'b1);
        neg_r <= 16'h0000;
        frames(16);
        check("drop", start_o, 1'b0);
        blk_r <= 1'b1;
        neg_r <= 16'h001E;
        frames(2);
        check("blocked", blocked_o, 1'b1);
        check("blk_start", start_o, 1'b0);
        blk_r <= 1'b0;
        neg_r <= 16'h0000;
        frames(2);
        wr(unbalance_pkg::ADDR_CTRL, 32'h0000_0005);
        neg_r <= 16'h001E;
        frames(10);
        check("dt_early", trip_o, 1'b0);
        frames(12);
        check("dt_trip", trip_o, 1'b1);
        neg_r <= 16'h0000;
        frames(16);
        neg_r <= 16'h001E;
        frames(4);
        blk_r <= 1'b1;
        frames(2);
        check("late_blk", start_o, 1'b0);
        frames(20);
        check("no_trip", trip_o, 1'b0);
        // After the release the held pick-up meets blocking: blocked.
        check("rel_blk", blocked_o, 1'b1);
        blk_r <= 1'b0;
        neg_r <= 16'h0000;
        frames(16);
        wr(unbalance_pkg::ADDR_CTRL, 32'h0000_00E1);
        frames(1);
        check("forced", condition_o, unbalance_pkg::COND_BLOCKED);
        wr(unbalance_pkg::ADDR_CTRL, 32'h0000_00C1);
        frames(1);
        check("unforced", condition_o, unbalance_pkg::COND_NORMAL);
        rc("trips", unbalance_pkg::ADDR_CNT_TRIP, 32'h0000_0002);
        // Blocked rose three times: pick-up, after release, forcing.
        rc("blocks", unbalance_pkg::ADDR_CNT_BLOCK, 32'h0000_0003);
        wr(unbalance_pkg::ADDR_CNT_CLEAR, 32'h0000_0007);
        rc("cleared", unbalance_pkg::ADDR_CNT_TRIP, 32'h0000_0000);
        // Group 1 ratio level 30 %: 30 on 100 sits on it, 32 is above.
        wr(9'h064, 32'h0000_0BB8);
        wr(unbalance_pkg::ADDR_CTRL, 32'h0000_0102);
        neg_r <= 16'h001E;
        frames(3);
        check("ratio_eq", start_o, 1'b0);
        neg_r <= 16'h0020;
        frames(3);
        check("ratio_trip", trip_o, 1'b1);
        // Curve, k 12000, 40 on 20: 6000 a frame after pick-up, third frame trips.
        neg_r <= 16'h0000;
        wr(9'h050, 32'h0000_2EE0);
        wr(unbalance_pkg::ADDR_CTRL, 32'h0000_0009);
        frames(3);
        neg_r <= 16'h0028;
        frames(3);
        check("curve_early", trip_o, 1'b0);
        check("curve_start", start_o, 1'b1);
        frames(1);
        check("curve_trip", trip_o, 1'b1);
        complete_run();
    end
endmodule // unbalance_stage_tb
